// ===== src/mfc_defs.svh
// Offsets, field positions and reset values of the MAC FIFO control slice.
`ifndef MFC_DEFS_SVH
`define MFC_DEFS_SVH
`define MFC_ADDR_W        10
`define MFC_OFF_CFG       10'h05C
`define MFC_OFF_WCTL      10'h060
`define MFC_OFF_WDLO      10'h064
`define MFC_OFF_RCTL      10'h068
`define MFC_OFF_LVL       10'h058
`define MFC_TX_RAM_ADDRESS_WIDTH 11
`define MFC_RAM_AW        `MFC_TX_RAM_ADDRESS_WIDTH
`define MFC_F_COND        17:0
`define MFC_F_CTRL        39:32
`define MFC_RX_CAP        12'hFFF
`define MFC_MIN_FRAME     16'h0040
`define MFC_B_HDPLX       22
`define MFC_B_FULL        21
`define MFC_B_FULLCLR     20
`define MFC_B_BYTE        19
`define MFC_B_SHORT       18
`define MFC_B_REQ         31
`define MFC_B_ACK         30
`define MFC_B_PTRLD       12
`define MFC_CFG_WMASK     32'h005F_FFFF
`define MFC_CFG_RST       32'h000B_FFF7
`define MFC_WCTL_WMASK    32'h80FF_1FFF
`define MFC_LVL_WMASK     32'h0003_FFFF
`define MFC_LVL_RST       32'h0000_0008
`define MFC_ZERO32        32'h0000_0000
`endif

// ===== src/mfc_pkg.sv
// Types shared by the MAC FIFO control slice.
package mfc_pkg;
  // Receive statistics vector reported once per received frame.
  typedef struct packed {
    logic        valid;  // One-cycle pulse at end of frame.
    logic [15:0] len;    // Frame length in bytes.
    logic [17:0] vec;    // Statistics condition bits.
  } mfc_rx_stat_t;
  // One word pushed into the transmit RAM by the fabric side.
  typedef struct packed {
    logic        valid;  // One-cycle pulse per word.
    logic [39:0] data;   // Control byte over four data bytes.
  } mfc_tx_word_t;
  // Debug RAM access handshake states.
  typedef enum logic [2:0] {
    MFC_IDLE = 3'b001,
    MFC_WACK = 3'b010,
    MFC_RACK = 3'b100
  } mfc_state_t;
endpackage

// ===== src/mfc_top.sv
// Control slice of the MAC frame FIFO: flow control, drop filter and TX RAM debug port.
//
// How it works
// - Half-duplex bit selects backpressure, else pause frames.
// - Full flag rises when receive level reaches capacity.
// - Held clear control forces full flag low.
// - Byte-mode bit picks byte or nibble transfers.
// - Short-frame enable drops frames under 64 bytes.
// - Mask bit set ignores that statistics condition.
// - Drop frame when at least one condition is compared and all compared conditions match.
// - Eighteen drop levels, one per condition.
// - Write ack rises on acceptance, falls after request.
// - Upper byte supplies word bits 39 to 32.
// - Bits 33:32 encode valid bytes of last word.
// - Address top bit selects RAM write or pointer load.
// - Address field reads back the live write pointer.
// - Low data register supplies word bits 31 to 0.
// - Read ack rises once word returned, follows request.
// - Read upper byte returns word bits 39 to 32.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "mfc_defs.svh"
module mfc_top
  import mfc_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire logic [`MFC_ADDR_W-1:0] avs_address,
  input  wire logic                   avs_read,
  input  wire logic                   avs_write,
  input  wire logic [31:0]            avs_writedata,
  input  wire logic [3:0]             avs_byteenable,
  output logic [31:0]                 avs_readdata,
  output logic                        avs_waitrequest,
  input  wire logic [11:0]            rx_fill_words,
  input  wire mfc_rx_stat_t           rx_stat,
  input  wire mfc_tx_word_t           tx_push,
  output logic                        flow_backpressure,
  output logic                        byte_mode,
  output logic                        rx_full,
  output logic                        rx_frame_drop,
  output logic [`MFC_RAM_AW:0]        tx_wr_ptr
);

  // Byte-lane merge used by every writable register except the read request bit, which takes lane 3 directly.
  function automatic logic [31:0] merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                        input logic [3:0] be, input logic [31:0] wmask);
    logic [31:0] lanes;
    lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wmask;
    merge = (old_v & ~lanes) | (new_v & lanes);
  endfunction

  logic [31:0]          cfg_reg;       // Flow, width and filter configuration.
  logic [31:0]          wctl_reg;      // Write request, upper data byte, address.
  logic [31:0]          wdlo_reg;      // Lower data word for RAM writes.
  logic                 rreq_reg;      // Read request bit.
  logic [31:0]          lvl_reg;       // Drop levels per condition.
  logic [7:0]           rdat_hi_reg;   // Upper byte of the last word read.
  logic                 full_reg;      // Sticky receive full indicator.
  logic                 drop_reg;      // One-cycle drop decision.
  logic [`MFC_RAM_AW:0] ptr_reg;       // Transmit module write pointer.
  logic [31:0]          rdata_reg;     // Bus read data.
  logic                 wait_reg;      // Bus waitrequest.
  mfc_state_t           st_reg;        // Debug access handshake state.
  mfc_state_t           st_next;       // Next handshake state.
  logic [39:0]          ram [0:(1 << `MFC_RAM_AW)-1];  // Transmit FIFO storage.

  // A request is answered on the second edge it is seen; writes land at that edge.
  wire bus_req  = avs_read | avs_write;
  wire bus_take = avs_write & ~wait_reg;
  wire sel_cfg  = avs_address == `MFC_OFF_CFG;
  wire sel_wctl = avs_address == `MFC_OFF_WCTL;
  wire sel_wdlo = avs_address == `MFC_OFF_WDLO;
  wire sel_rctl = avs_address == `MFC_OFF_RCTL;
  wire sel_lvl  = avs_address == `MFC_OFF_LVL;

  // Handshake decode; acknowledges are the state itself, never written by software.
  wire                   wreq     = wctl_reg[`MFC_B_REQ];
  wire                   wack     = st_reg == MFC_WACK;
  wire                   rack     = st_reg == MFC_RACK;
  wire                   ptr_load = wctl_reg[`MFC_B_PTRLD];
  wire [`MFC_RAM_AW-1:0] ram_adx  = wctl_reg[`MFC_RAM_AW-1:0];
  wire [39:0]            wword    = {wctl_reg[23:16], wdlo_reg};
  wire                   do_write = (st_reg == MFC_IDLE) & wreq;
  wire                   do_read  = (st_reg == MFC_IDLE) & ~wreq & rreq_reg;
  wire [7:0]             ram_hi   = ram[ram_adx][`MFC_F_CTRL];

  // Drop filter: short frames, or every unmasked condition at its level when at least one is unmasked.
  wire [17:0] mask     = cfg_reg[`MFC_F_COND];
  wire        all_mask = &mask;
  wire        lvl_hit  = &(mask | ~(rx_stat.vec ^ lvl_reg[`MFC_F_COND]));
  wire        short_f  = cfg_reg[`MFC_B_SHORT] & (rx_stat.len < `MFC_MIN_FRAME);
  wire        drop_now = rx_stat.valid & (short_f | (lvl_hit & ~all_mask));

  // Full flag: the held clear wins, so it stays low until software releases it.
  wire full_next = ~cfg_reg[`MFC_B_FULLCLR] &
                   (full_reg | (rx_fill_words >= `MFC_RX_CAP));

  // Read multiplexer; reserved and unmapped bits read zero.
  wire [31:0] rd_cfg  = cfg_reg | ({31'h0000_0000, full_reg} << `MFC_B_FULL);
  wire [31:0] rd_wctl = {wreq, wack, 6'h00, wctl_reg[23:16], 3'h0, 1'b0, ptr_reg};
  wire [31:0] rd_rctl = {rreq_reg, rack, 6'h00, rdat_hi_reg, 16'h0000};
  wire [31:0] rd_mux  = sel_cfg  ? rd_cfg :
                        sel_wctl ? rd_wctl :
                        sel_wdlo ? wdlo_reg :
                        sel_rctl ? rd_rctl :
                        sel_lvl  ? lvl_reg : `MFC_ZERO32;

  // Handshake state machine for debug RAM access.
  always_comb begin
    st_next = st_reg;
    case (st_reg)
      MFC_IDLE: begin
        if (do_write) begin
          st_next = MFC_WACK;
        end else if (do_read) begin
          st_next = MFC_RACK;
        end
      end
      MFC_WACK: begin
        if (!wreq) begin
          st_next = MFC_IDLE;
        end
      end
      MFC_RACK: begin
        if (!rreq_reg) begin
          st_next = MFC_IDLE;
        end
      end
      default: begin
        st_next = MFC_IDLE;
      end
    endcase
  end

  // Bus slave handshake and read data capture.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_reg  <= 1'b1;
      rdata_reg <= `MFC_ZERO32;
    end else begin
      wait_reg  <= ~(bus_req & wait_reg);
      rdata_reg <= (avs_read & wait_reg) ? rd_mux : rdata_reg;
    end
  end

  // Software-written registers; acknowledge and read-only bits are masked out.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_reg  <= `MFC_CFG_RST;
      wctl_reg <= `MFC_ZERO32;
      wdlo_reg <= `MFC_ZERO32;
      rreq_reg <= 1'b0;
      lvl_reg  <= `MFC_LVL_RST;
    end else if (bus_take) begin
      if (sel_cfg) begin
        cfg_reg <= merge(cfg_reg, avs_writedata, avs_byteenable, `MFC_CFG_WMASK);
      end
      if (sel_wctl) begin
        wctl_reg <= merge(wctl_reg, avs_writedata, avs_byteenable, `MFC_WCTL_WMASK);
      end
      if (sel_wdlo) begin
        wdlo_reg <= merge(wdlo_reg, avs_writedata, avs_byteenable, 32'hFFFF_FFFF);
      end
      if (sel_rctl && avs_byteenable[3]) begin
        rreq_reg <= avs_writedata[`MFC_B_REQ];
      end
      if (sel_lvl) begin
        lvl_reg <= merge(lvl_reg, avs_writedata, avs_byteenable, `MFC_LVL_WMASK);
      end
    end
  end

  // Status, pointer and handshake state.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_reg      <= MFC_IDLE;
      full_reg    <= 1'b0;
      drop_reg    <= 1'b0;
      ptr_reg     <= '0;
      rdat_hi_reg <= 8'h00;
    end else begin
      st_reg   <= st_next;
      full_reg <= full_next;
      drop_reg <= drop_now;
      if (do_write && ptr_load) begin
        ptr_reg <= wctl_reg[`MFC_RAM_AW:0];
      end else if (tx_push.valid) begin
        ptr_reg <= ptr_reg + 1'b1;
      end
      if (do_read) begin
        rdat_hi_reg <= ram_hi;
      end
    end
  end

  // Transmit RAM: the debug write takes priority; the path is idle then anyway.
  always_ff @(posedge clk) begin
    if (do_write && !ptr_load) begin
      ram[ram_adx] <= wword;
    end else if (tx_push.valid) begin
      ram[ptr_reg[`MFC_RAM_AW-1:0]] <= tx_push.data;
    end
  end

  assign avs_readdata      = rdata_reg;
  assign avs_waitrequest   = wait_reg;
  assign flow_backpressure = cfg_reg[`MFC_B_HDPLX];
  assign byte_mode         = cfg_reg[`MFC_B_BYTE];
  assign rx_full           = full_reg;
  assign rx_frame_drop     = drop_reg;
  assign tx_wr_ptr         = ptr_reg;

  // Checks on the logic above.
  property p_flow;
    @(posedge clk) disable iff (!arst_n)
      bus_take && sel_cfg && avs_byteenable[2]
        |=> flow_backpressure == $past(avs_writedata[`MFC_B_HDPLX]);
  endproperty
  a_flow: assert property (p_flow) else $error("flow mode not taken");

  property p_byte;
    @(posedge clk) disable iff (!arst_n)
      bus_take && sel_cfg && avs_byteenable[2]
        |=> byte_mode == $past(avs_writedata[`MFC_B_BYTE]);
  endproperty
  a_byte: assert property (p_byte) else $error("byte mode not taken");

  property p_full_set;
    @(posedge clk) disable iff (!arst_n)
      rx_fill_words >= `MFC_RX_CAP && !cfg_reg[`MFC_B_FULLCLR] |=> rx_full;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag missed");

  property p_full_clr;
    @(posedge clk) disable iff (!arst_n)
      cfg_reg[`MFC_B_FULLCLR] |=> !rx_full;
  endproperty
  a_full_clr: assert property (p_full_clr) else $error("full flag not cleared");

  property p_wack;
    @(posedge clk) disable iff (!arst_n)
      $rose(wack) |-> wreq ##0 (wack throughout (wreq [*1]));
  endproperty
  a_wack: assert property (p_wack) else $error("write ack without request");

  property p_wack_fall;
    @(posedge clk) disable iff (!arst_n)
      wack && !wreq |=> !wack;
  endproperty
  a_wack_fall: assert property (p_wack_fall) else $error("write ack stuck");

  property p_rack;
    @(posedge clk) disable iff (!arst_n)
      $rose(rack) |-> rreq_reg && $past(rreq_reg) && rdat_hi_reg == $past(ram_hi);
  endproperty
  a_rack: assert property (p_rack) else $error("read ack without request");

  property p_short;
    @(posedge clk) disable iff (!arst_n)
      rx_stat.valid && cfg_reg[`MFC_B_SHORT] && rx_stat.len < `MFC_MIN_FRAME |=> rx_frame_drop;
  endproperty
  a_short: assert property (p_short) else $error("short frame kept");

  property p_match;
    @(posedge clk) disable iff (!arst_n)
      rx_stat.valid && !all_mask && ((rx_stat.vec ^ lvl_reg[17:0]) & ~mask) == 18'h0_0000
        |=> rx_frame_drop;
  endproperty
  a_match: assert property (p_match) else $error("matching frame kept");

  property p_ptr;
    @(posedge clk) disable iff (!arst_n)
      do_write && ptr_load |=> tx_wr_ptr == $past(wctl_reg[`MFC_RAM_AW:0]);
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer not loaded");

endmodule

// ===== sim/mfc_mac_model.sv
// Behavioural model of the MAC datapath that faces the control slice.
`timescale 1ns/1ps
module mfc_mac_model
  import mfc_pkg::*;
(
  input  wire logic   clk,
  output logic [11:0] fill,
  output mfc_rx_stat_t stat,
  output mfc_tx_word_t push
);
  // Everything idles at time zero so no input of the slice floats.
  initial begin
    fill = 12'h000;
    stat = '0;
    push = '0;
  end
  // The storage level moves only just after an edge.
  task automatic set_fill(input logic [11:0] v);
    @(posedge clk);
    fill <= v;
  endtask
  // A one-cycle end-of-frame vector; returns at the edge that takes it.
  task automatic send_stat(input logic [15:0] len, input logic [17:0] vec);
    @(posedge clk);
    stat <= '{1'b1, len, vec};
    @(posedge clk);
    stat.valid <= 1'b0;
  endtask
  // One word pushed by the fabric side, which advances the write pointer.
  task automatic push_word(input logic [39:0] d);
    @(posedge clk);
    push <= '{1'b1, d};
    @(posedge clk);
    push.valid <= 1'b0;
  endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the MAC FIFO control slice.
`timescale 1ns/1ps
`include "mfc_defs.svh"
module testbench;
  import mfc_pkg::*;
  logic         clk, arst_n, avs_read, avs_write, avs_waitrequest;
  logic         flow_backpressure, byte_mode, rx_full, rx_frame_drop;
  logic [9:0]   avs_address;
  logic [31:0]  avs_writedata, avs_readdata, rd;
  logic [11:0]  fill, tx_wr_ptr;
  logic [7:0]   up;
  logic [3:0]   be;
  mfc_rx_stat_t stat;
  mfc_tx_word_t push;
  int           num_errors, total_checks;
  // Free-running 100 MHz clock.
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // Byte lanes are all enabled except in the lane-masking test.
  mfc_top mfc_top_inst (.clk(clk), .arst_n(arst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .rx_fill_words(fill), .rx_stat(stat),
    .tx_push(push), .flow_backpressure(flow_backpressure), .byte_mode(byte_mode),
    .rx_full(rx_full), .rx_frame_drop(rx_frame_drop), .tx_wr_ptr(tx_wr_ptr));
  mfc_mac_model mfc_mac_model_inst (.clk(clk), .fill(fill), .stat(stat), .push(push));
  // Prints the counts and the verdict, then stops the run.
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    check_word({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask
  // One bus cycle held until waitrequest is sampled low; read data lands in rd.
  task automatic bus(input logic wr, input logic [9:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    for (int i = 0; i <= 20; i++) begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0) begin
        rd = avs_readdata;
        break;
      end
      if (i == 20) begin
        num_errors++;
        final_report();
      end
    end
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic expect_reg(input logic [9:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    check_word(rd, exp);
  endtask
  // Reads until one bit shows the wanted level; a bounded wait.
  task automatic poll(input logic [9:0] a, input int b, input logic v);
    for (int i = 0; i <= 20; i++) begin
      bus(1'b0, a, 32'h0000_0000);
      if (rd[b] === v) break;
      if (i == 20) begin
        num_errors++;
        final_report();
      end
    end
  endtask
  // Sends one statistics vector and checks the one-cycle drop pulse.
  task automatic frame(input logic [15:0] len, input logic [17:0] vec, input logic exp);
    mfc_mac_model_inst.send_stat(len, vec);
    @(negedge clk);
    check_bit(rx_frame_drop, exp);
    @(negedge clk);
    check_bit(rx_frame_drop, 1'b0);
  endtask
  initial begin
    arst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h0000_0000;
    be = 4'hF;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    expect_reg(`MFC_OFF_CFG, 32'h000B_FFF7);
    check_bit(byte_mode, 1'b1);
    check_bit(flow_backpressure, 1'b0);
    expect_reg(`MFC_OFF_WCTL, 32'h0000_0000);
    expect_reg(`MFC_OFF_RCTL, 32'h0000_0000);
    expect_reg(`MFC_OFF_LVL, 32'h0000_0008);
    expect_reg(10'h070, 32'h0000_0000);
    $display("test reset done");
    // Reserved and read-only bits must not take the written ones.
    bus(1'b1, `MFC_OFF_CFG, 32'hFFFF_FFFF);
    expect_reg(`MFC_OFF_CFG, 32'h005F_FFFF);
    bus(1'b1, `MFC_OFF_CFG, 32'h0040_0000);
    @(negedge clk);
    check_bit(flow_backpressure, 1'b1);
    check_bit(byte_mode, 1'b0);
    $display("test config done");
    // One word below capacity must not flag; at capacity it must.
    mfc_mac_model_inst.set_fill(12'hFFE);
    repeat (3) @(negedge clk);
    check_bit(rx_full, 1'b0);
    mfc_mac_model_inst.set_fill(12'hFFF);
    repeat (3) @(negedge clk);
    check_bit(rx_full, 1'b1);
    expect_reg(`MFC_OFF_CFG, 32'h0060_0000);
    bus(1'b1, `MFC_OFF_CFG, 32'h0050_0000);
    poll(`MFC_OFF_CFG, 21, 1'b0);
    repeat (3) @(negedge clk);
    check_bit(rx_full, 1'b0);
    bus(1'b1, `MFC_OFF_CFG, 32'h0040_0000);
    repeat (3) @(negedge clk);
    check_bit(rx_full, 1'b1);
    mfc_mac_model_inst.set_fill(12'h000);
    $display("test full flag done");
    // Short frames at the 64-byte boundary, with every condition masked.
    bus(1'b1, `MFC_OFF_CFG, 32'h0007_FFFF);
    frame(16'h003F, 18'h0_0000, 1'b1);
    frame(16'h0040, 18'h0_0000, 1'b0);
    // Only condition 4 is compared, against a level of one.
    bus(1'b1, `MFC_OFF_CFG, 32'h0003_FFEF);
    bus(1'b1, `MFC_OFF_LVL, 32'h0000_0010);
    frame(16'h0064, 18'h0_0010, 1'b1);
    frame(16'h0064, 18'h0_0000, 1'b0);
    frame(16'h0020, 18'h3_FFEF, 1'b0);
    $display("test drop filter done");
    // Every valid-byte code is written to its own word, then read back.
    for (int c = 0; c < 4; c++) begin
      up = 8'hB8 | 8'(c);
      bus(1'b1, `MFC_OFF_WDLO, 32'h1234_5670 + 32'(c));
      expect_reg(`MFC_OFF_WDLO, 32'h1234_5670 + 32'(c));
      bus(1'b1, `MFC_OFF_WCTL, {8'h80, up, 14'h0000, 2'(c)});
      poll(`MFC_OFF_WCTL, 30, 1'b1);
      bus(1'b1, `MFC_OFF_WCTL, {8'h00, up, 14'h0000, 2'(c)});
      poll(`MFC_OFF_WCTL, 30, 1'b0);
      bus(1'b1, `MFC_OFF_RCTL, 32'h8000_0000);
      poll(`MFC_OFF_RCTL, 30, 1'b1);
      check_word(rd, {8'hC0, up, 16'h0000});
      bus(1'b1, `MFC_OFF_RCTL, 32'h0000_0000);
      poll(`MFC_OFF_RCTL, 30, 1'b0);
    end
    $display("test ram access done");
    // The acknowledge bit ignores writes; a pointer load reads back live.
    bus(1'b1, `MFC_OFF_WCTL, 32'h4000_0000);
    expect_reg(`MFC_OFF_WCTL, 32'h0000_0000);
    bus(1'b1, `MFC_OFF_WCTL, 32'h8000_1123);
    poll(`MFC_OFF_WCTL, 30, 1'b1);
    check_word(rd, 32'hC000_0123);
    check_word({20'h0_0000, tx_wr_ptr}, 32'h0000_0123);
    bus(1'b1, `MFC_OFF_WCTL, 32'h0000_0000);
    poll(`MFC_OFF_WCTL, 30, 1'b0);
    mfc_mac_model_inst.push_word(40'h00_0000_0000);
    expect_reg(`MFC_OFF_WCTL, 32'h0000_0124);
    // Only lane 3 enabled: the level register holds nothing there to take.
    be <= 4'h8;
    bus(1'b1, `MFC_OFF_LVL, 32'h0003_FFFF);
    be <= 4'hF;
    expect_reg(`MFC_OFF_LVL, 32'h0000_0010);
    $display("test pointer done");
    final_report();
  end
endmodule
